// [logic/cfs_pkg.sv]
`default_nettype none

package cfs_pkg;
  // Bit index bounds of the fields, then stuffing, length, CRC and FIFO constants
  localparam logic [6:0] ARB_LAST = 7'h0c;
  localparam logic [6:0] ID_LAST = 7'h0b;
  localparam logic [6:0] EXT_LAST = 7'h12;
  localparam logic [6:0] DLC_FIRST = 7'h02;
  localparam logic [6:0] CTRL_LAST = 7'h05;
  localparam logic [6:0] CRC_LAST = 7'h0e;
  localparam logic [6:0] EOF_LAST = 7'h06;
  localparam logic [6:0] INTERM_LAST = 7'h02;
  localparam logic [6:0] SUSP_LAST = 7'h07;
  localparam logic [6:0] FLAG_LAST = 7'h05;
  localparam logic [6:0] DELIM_LAST = 7'h07;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [14:0] CRC_INIT = 15'h0000;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ARB, ST_EXT, ST_CTRL, ST_DATA, ST_CRC, ST_CRC_DEL, ST_ACK_SLOT,
    ST_ACK_DEL, ST_EOF, ST_INTERM, ST_SUSPEND, ST_FLAG, ST_DELIM
  } cfs_state_t;

  typedef enum logic [2:0] {
    CFS_ERR_NONE, CFS_ERR_BIT, CFS_ERR_STUFF, CFS_ERR_FORM, CFS_ERR_ACK, CFS_ERR_CRC
  } cfs_err_t;
endpackage : cfs_pkg

`default_nettype wire

// [logic/cfs_field_seq.sv]
`timescale 1ns/100ps
`default_nettype none

module cfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [CW-1:0] next_count;
  logic next_in_ready, push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + CW'(push) - CW'(pop);
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end
    next_in_ready = next_count != CW'(DEPTH);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr];
  assign out_valid = count != '0;
endmodule : cfs_fifo

module cfs_field_seq
  import cfs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bit timing and bus
  input wire logic bit_tick,
  input wire logic bus_rx,
  output logic bus_tx,
  // Node state
  input wire logic err_passive,
  // Transmit request
  input wire logic tx_req,
  input wire logic [10:0] tx_id,
  input wire logic tx_rtr,
  input wire logic [3:0] tx_dlc,
  output logic tx_busy,
  output logic tx_done,
  // Transmit data
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // Received frame
  output logic [10:0] rx_id,
  output logic rx_rtr,
  output logic rx_ext,
  output logic [3:0] rx_dlc,
  output logic [7:0] rx_data,
  output logic rx_data_valid,
  output logic rx_ok,
  // Errors and overload
  output logic err_pulse,
  output var cfs_err_t err_code,
  output logic ovl_pulse
);
  cfs_state_t state, next_state;
  cfs_err_t err, next_err_code;
  logic [6:0] idx, next_idx, data_last;
  logic [14:0] crc, next_crc;
  logic [2:0] stuff_cnt, next_cnt;
  logic [10:0] tid, next_tid, next_rx_id;
  logic [3:0] tdlc, next_tdlc, next_rx_dlc, byte_cnt, need, fifo_count;
  logic [7:0] tx_byte, next_txd, next_rxd, fifo_data;
  logic last_bit, next_last, trtr, next_trtr, crc_bad, next_crc_bad;
  logic flag_dom, next_flag_dom, next_busy, next_ext, next_rtr;
  logic next_bus_tx, next_rx_valid, next_rx_ok, next_tx_done, next_ovl;
  logic stuffed, adv, start_ovl, pop, flush, fifo_valid;

  function automatic logic [14:0] crc_step(input logic [14:0] c, input logic d);
    crc_step = {c[13:0], 1'b0} ^ ((d ^ c[14]) ? CRC_POLY : CRC_INIT);
  endfunction : crc_step

  cfs_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .flush(flush),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .count(fifo_count)
  );

  // ****************************************
  // Field sequencing
  // ****************************************
  always_comb begin
    stuffed = state inside {ST_ARB, ST_EXT, ST_CTRL, ST_DATA, ST_CRC};
    byte_cnt = (rx_dlc > MAX_BYTES) ? MAX_BYTES : rx_dlc;
    data_last = {byte_cnt, 3'b000} - 7'h1;
    need = tx_rtr ? 4'h0 : ((tx_dlc > MAX_BYTES) ? MAX_BYTES : tx_dlc);
    next_state = state;
    next_idx = idx;
    next_busy = tx_busy;
    next_ext = rx_ext;
    next_rtr = rx_rtr;
    next_rx_dlc = rx_dlc;
    next_rx_id = rx_id;
    next_crc = crc;
    next_cnt = stuff_cnt;
    next_last = last_bit;
    next_rxd = rx_data;
    next_txd = tx_byte;
    next_tid = tid;
    next_tdlc = tdlc;
    next_trtr = trtr;
    next_crc_bad = crc_bad;
    next_flag_dom = flag_dom;
    next_err_code = err_code;
    next_rx_valid = 1'b0;
    next_rx_ok = 1'b0;
    next_tx_done = 1'b0;
    next_ovl = 1'b0;
    err = CFS_ERR_NONE;
    adv = 1'b0;
    start_ovl = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    if (bit_tick) begin
      case (state)
        ST_IDLE, ST_SUSPEND: begin
          if (!bus_rx) begin
            // dominant start bit from another node
            next_state = ST_ARB;
            next_idx = 7'h1;
            next_busy = 1'b0;
            next_ext = 1'b0;
            next_crc = crc_step(CRC_INIT, 1'b0);
            next_cnt = 3'h1;
            next_last = 1'b0;
          end else if (state == ST_SUSPEND) begin
            next_idx = idx + 7'h1;
            if (idx == SUSP_LAST) begin
              next_state = ST_IDLE;
              next_busy = 1'b0;
            end
          end else if (tx_req && fifo_count >= need) begin
            next_state = ST_ARB;
            next_idx = 7'h0;
            next_busy = 1'b1;
            next_ext = 1'b0;
            next_crc = CRC_INIT;
            next_cnt = 3'h0;
            next_last = 1'b1;
            next_tid = tx_id;
            next_trtr = tx_rtr;
            next_tdlc = tx_dlc;
          end
        end
        ST_ARB, ST_EXT, ST_CTRL, ST_DATA, ST_CRC: begin
          if (stuff_cnt == STUFF_RUN) begin
            // drop stuff bit, check its polarity
            if (bus_rx == last_bit) begin
              err = tx_busy ? CFS_ERR_BIT : CFS_ERR_STUFF;
            end
            next_cnt = 3'h1;
            next_last = bus_rx;
            if (state == ST_CRC && idx > CRC_LAST) begin
              next_state = ST_CRC_DEL;
              next_idx = 7'h0;
            end
          end else begin
            adv = 1'b1;
            next_cnt = (bus_rx == last_bit) ? stuff_cnt + 3'h1 : 3'h1;
            next_last = bus_rx;
            if (tx_busy && state == ST_CRC) begin
              next_crc = {crc[13:0], 1'b0};
            end else begin
              next_crc = crc_step(crc, bus_rx);
            end
            if (tx_busy && bus_rx != bus_tx) begin
              if (state == ST_ARB && bus_tx) begin
                next_busy = 1'b0;
              end else begin
                err = CFS_ERR_BIT;
              end
            end
            next_idx = idx + 7'h1;
            case (state)
              ST_ARB: begin
                if (idx != 7'h0 && idx <= ID_LAST) begin
                  next_rx_id = {rx_id[9:0], bus_rx};
                end
                if (idx == ARB_LAST) begin
                  next_rtr = bus_rx;
                  next_state = ST_CTRL;
                  next_idx = 7'h0;
                end
              end
              ST_EXT: begin
                if (idx == EXT_LAST) begin
                  next_rtr = bus_rx;
                  next_state = ST_CTRL;
                  next_idx = 7'h0;
                end
              end
              ST_CTRL: begin
                // extended frame, followed but not stored
                if (idx == 7'h0 && !rx_ext && bus_rx && !tx_busy) begin
                  next_ext = 1'b1;
                  next_state = ST_EXT;
                  next_idx = 7'h0;
                end else begin
                  // length code after two reserved bits
                  if (idx >= DLC_FIRST) begin
                    next_rx_dlc = {rx_dlc[2:0], bus_rx};
                  end
                  if (idx == CTRL_LAST) begin
                    next_idx = 7'h0;
                    // remote or empty frame skips data
                    if (rx_rtr || next_rx_dlc == 4'h0) begin
                      next_state = ST_CRC;
                    end else begin
                      next_state = ST_DATA;
                    end
                  end
                end
              end
              ST_DATA: begin
                next_rxd = {rx_data[6:0], bus_rx};
                next_rx_valid = idx[2:0] == 3'h7 && !tx_busy && !rx_ext;
                if (idx == data_last) begin
                  next_state = ST_CRC;
                  next_idx = 7'h0;
                end
              end
              default: begin
                // run ending the CRC still stuffed
                if (idx == CRC_LAST && next_cnt != STUFF_RUN) begin
                  next_state = ST_CRC_DEL;
                  next_idx = 7'h0;
                end
              end
            endcase
          end
        end
        ST_CRC_DEL: begin
          if (!bus_rx) begin
            err = CFS_ERR_FORM;
          end
          // nonzero remainder is a CRC error
          next_crc_bad = !tx_busy && crc != CRC_INIT;
          next_state = ST_ACK_SLOT;
        end
        ST_ACK_SLOT: begin
          if (tx_busy && bus_rx) begin
            err = CFS_ERR_ACK;
          end
          next_state = ST_ACK_DEL;
        end
        ST_ACK_DEL: begin
          if (!bus_rx) begin
            err = CFS_ERR_FORM;
          end else if (crc_bad) begin
            err = CFS_ERR_CRC;
          end else begin
            next_state = ST_EOF;
            next_idx = 7'h0;
          end
        end
        ST_EOF: begin
          if (!bus_rx && !(idx == EOF_LAST && !tx_busy)) begin
            err = CFS_ERR_FORM;
          end else if (idx == EOF_LAST) begin
            next_rx_ok = !tx_busy && !rx_ext;
            next_tx_done = tx_busy;
            next_state = ST_INTERM;
            next_idx = 7'h0;
            start_ovl = !bus_rx;
          end else begin
            next_idx = idx + 7'h1;
          end
        end
        ST_INTERM: begin
          if (!bus_rx) begin
            start_ovl = 1'b1;
          end else if (idx == INTERM_LAST) begin
            next_idx = 7'h0;
            if (err_passive && tx_busy) begin
              next_state = ST_SUSPEND;
            end else begin
              next_state = ST_IDLE;
              next_busy = 1'b0;
            end
          end else begin
            next_idx = idx + 7'h1;
          end
        end
        ST_FLAG: begin
          next_idx = idx + 7'h1;
          if (idx == FLAG_LAST) begin
            next_state = ST_DELIM;
            next_idx = 7'h0;
          end
        end
        ST_DELIM: begin
          // eight recessive bits end the delimiter
          if (!bus_rx) begin
            next_idx = 7'h0;
          end else if (idx == DELIM_LAST) begin
            next_state = ST_INTERM;
            next_idx = 7'h0;
          end else begin
            next_idx = idx + 7'h1;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
      if (start_ovl) begin
        next_state = ST_FLAG;
        next_idx = 7'h0;
        next_flag_dom = 1'b1;
        next_ovl = 1'b1;
      end
      // flag begins at the next bit
      if (err != CFS_ERR_NONE) begin
        next_state = ST_FLAG;
        next_idx = 7'h0;
        next_flag_dom = !err_passive;
        next_err_code = err;
        next_crc_bad = 1'b0;
        flush = tx_busy;
      end
    end
    if (adv && err == CFS_ERR_NONE && next_busy && next_state == ST_DATA &&
        next_idx[2:0] == 3'h0) begin
      pop = fifo_valid;
      next_txd = fifo_data;
    end
    // ****************************************
    // Next transmitted bit
    // ****************************************
    // fixed fields recessive
    next_bus_tx = 1'b1;
    if (next_state == ST_FLAG) begin
      next_bus_tx = !next_flag_dom;
    end else if (next_busy && next_state inside {ST_ARB, ST_CTRL, ST_DATA, ST_CRC}) begin
      if (next_cnt == STUFF_RUN) begin
        next_bus_tx = !next_last;
      end else begin
        case (next_state)
          ST_ARB: begin
            if (next_idx == 7'h0) begin
              next_bus_tx = 1'b0;
            end else if (next_idx <= ID_LAST) begin
              next_bus_tx = next_tid[4'(ID_LAST - next_idx)];
            end else begin
              next_bus_tx = next_trtr;
            end
          end
          ST_CTRL: begin
            if (next_idx < DLC_FIRST) begin
              next_bus_tx = 1'b0;
            end else begin
              next_bus_tx = next_tdlc[2'(CTRL_LAST - next_idx)];
            end
          end
          ST_DATA: next_bus_tx = next_txd[3'(~next_idx[2:0])];
          ST_CRC: next_bus_tx = next_crc[14];
          default: next_bus_tx = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      idx <= 7'h0;
      tx_busy <= 1'b0;
      rx_ext <= 1'b0;
      rx_rtr <= 1'b0;
      rx_dlc <= 4'h0;
      rx_id <= 11'h000;
      crc <= CRC_INIT;
      stuff_cnt <= 3'h0;
      last_bit <= 1'b1;
      rx_data <= 8'h00;
      tx_byte <= 8'h00;
      tid <= 11'h000;
      tdlc <= 4'h0;
      trtr <= 1'b0;
      crc_bad <= 1'b0;
      flag_dom <= 1'b0;
      err_code <= CFS_ERR_NONE;
      bus_tx <= 1'b1;
      rx_data_valid <= 1'b0;
      rx_ok <= 1'b0;
      tx_done <= 1'b0;
      err_pulse <= 1'b0;
      ovl_pulse <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      tx_busy <= next_busy;
      rx_ext <= next_ext;
      rx_rtr <= next_rtr;
      rx_dlc <= next_rx_dlc;
      rx_id <= next_rx_id;
      crc <= next_crc;
      stuff_cnt <= next_cnt;
      last_bit <= next_last;
      rx_data <= next_rxd;
      tx_byte <= next_txd;
      tid <= next_tid;
      tdlc <= next_tdlc;
      trtr <= next_trtr;
      crc_bad <= next_crc_bad;
      flag_dom <= next_flag_dom;
      err_code <= next_err_code;
      bus_tx <= next_bus_tx;
      rx_data_valid <= next_rx_valid;
      rx_ok <= next_rx_ok;
      tx_done <= next_tx_done;
      err_pulse <= err != CFS_ERR_NONE;
      ovl_pulse <= next_ovl;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_hold_between_ticks: assert property (!bit_tick |=> $stable(state) && $stable(idx))
    else $error("field state moved without a sample point");
  a_reserved_dominant: assert property (
    state == ST_CTRL && tx_busy && idx < DLC_FIRST && stuff_cnt != STUFF_RUN |-> !bus_tx)
    else $error("reserved control bit not dominant");
  a_stuff_inverted: assert property (stuffed && tx_busy && stuff_cnt == STUFF_RUN
    |-> bus_tx != last_bit) else $error("stuff bit has wrong polarity");
  a_crc_sent: assert property (state == ST_CRC && tx_busy && stuff_cnt != STUFF_RUN
    |-> bus_tx == crc[14]) else $error("CRC bit differs from remainder");
  a_crc_checked: assert property (bit_tick && state == ST_CRC_DEL && !tx_busy
    && bus_rx && crc != CRC_INIT |=> crc_bad) else $error("bad remainder not caught");
  a_fixed_recessive: assert property (state inside {ST_CRC_DEL, ST_ACK_SLOT,
    ST_ACK_DEL, ST_EOF, ST_INTERM, ST_SUSPEND, ST_DELIM} |-> bus_tx)
    else $error("fixed field driven dominant");
  a_eof_length: assert property (bit_tick && state == ST_EOF && bus_rx
    |=> state == (($past(idx) == EOF_LAST) ? ST_INTERM : ST_EOF))
    else $error("end of frame not seven bits");
  a_no_start_interm: assert property (state == ST_INTERM && bit_tick && bus_rx
    |=> state != ST_ARB) else $error("frame started in intermission");
  a_suspend_entry: assert property (bit_tick && state == ST_INTERM &&
    idx == INTERM_LAST && bus_rx && err_passive && tx_busy |=> state == ST_SUSPEND)
    else $error("suspend field skipped");
  a_error_next_bit: assert property (bit_tick && err != CFS_ERR_NONE
    |=> state == ST_FLAG && idx == 7'h0 && err_pulse) else $error("error flag late");
  a_crc_after_delim: assert property (bit_tick && state == ST_ACK_DEL && bus_rx
    && crc_bad |=> state == ST_FLAG && err_code == CFS_ERR_CRC)
    else $error("CRC flag not after delimiter");
  a_flag_level: assert property (state == ST_FLAG |-> bus_tx == !flag_dom)
    else $error("flag level wrong");
  a_passive_flag: assert property (bit_tick && err != CFS_ERR_NONE && err_passive
    |=> bus_tx && state == ST_FLAG) else $error("passive flag drove dominant");
  a_delim_end: assert property (bit_tick && state == ST_DELIM && idx == DELIM_LAST
    && bus_rx |=> state == ST_INTERM) else $error("delimiter length wrong");

  c_tx_done: cover property (tx_done);
  c_rx_ok: cover property (rx_ok && rx_data_valid == 1'b0);
  c_error_flag: cover property (err_pulse && flag_dom);
  c_suspend: cover property (state == ST_SUSPEND);
endmodule : cfs_field_seq

`default_nettype wire

// [tb/cfs_bus_node.sv]
`timescale 1ns/100ps
`default_nettype none
// ****
// Far node: replays a bit pattern from SOF on
// ****
module cfs_bus_node (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  input wire logic bit_tick,
  input wire logic bus_lvl,
  output logic node_tx,
  // Pattern
  input wire logic arm,
  input wire logic [0:159] pat,
  input wire logic [7:0] len
);
  logic play;
  logic fin;
  logic [7:0] ptr;
  always @(posedge sys_clk) begin
    if (!rst_n || !arm) begin
      play <= 1'b0;
      fin <= 1'b0;
      ptr <= 8'h00;
      node_tx <= 1'b1;
    end else if (bit_tick) begin
      if (!play && !fin && !bus_lvl) begin
        play <= 1'b1;
        ptr <= 8'h02;
        node_tx <= pat[1];
      end else if (play && ptr < len) begin
        node_tx <= pat[ptr];
        ptr <= ptr + 8'h01;
      end else begin
        fin <= play | fin;
        play <= 1'b0;
        node_tx <= play | fin | pat[0];
      end
    end
  end
endmodule : cfs_bus_node
`default_nettype wire

// [tb/cfs_field_seq_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module cfs_field_seq_tb import cfs_pkg::*; ;
  logic sys_clk = 0, rst_n = 0, bit_tick = 0, tx_req = 0, tx_rtr = 0, err_passive = 0;
  logic wr_valid = 0, arm = 0, ovl;
  logic [10:0] tx_id = 0;
  logic [3:0] tx_dlc = 0;
  logic [7:0] wr_data = 0, plen = 0, last_rx = 0;
  logic [0:159] pat = '1;
  logic [1:0] tcnt = 0;
  logic bus_tx, tx_busy, tx_done, wr_ready, rx_rtr, rx_ext, rx_dv, rx_ok, err_pulse, node_tx;
  logic [10:0] rx_id;
  logic [3:0] rx_dlc;
  logic [7:0] rx_data;
  cfs_err_t err_code;
  logic exp [0:199];
  logic obs [0:199];
  int exp_len, num_errors = 0, check_count = 0, n_ok, n_dv, n_err, n_done, n_ovl;
  wire bus = bus_tx & node_tx;
  cfs_field_seq dut (.sys_clk(sys_clk), .rst_n(rst_n), .bit_tick(bit_tick), .bus_rx(bus),
    .bus_tx(bus_tx), .err_passive(err_passive), .tx_req(tx_req), .tx_id(tx_id),
    .tx_rtr(tx_rtr), .tx_dlc(tx_dlc), .tx_busy(tx_busy), .tx_done(tx_done),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rx_id(rx_id),
    .rx_rtr(rx_rtr), .rx_ext(rx_ext), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .rx_data_valid(rx_dv), .rx_ok(rx_ok), .err_pulse(err_pulse), .err_code(err_code),
    .ovl_pulse(ovl));
  cfs_bus_node peer (.sys_clk(sys_clk), .rst_n(rst_n), .bit_tick(bit_tick), .bus_lvl(bus),
    .node_tx(node_tx), .arm(arm), .pat(pat), .len(plen));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tcnt <= tcnt + 2'h1;
    bit_tick <= (tcnt == 2'h3);
    if (tx_busy === 1'b1) tx_req <= 1'b0;
    if (rx_ok === 1'b1) n_ok++;
    if (tx_done === 1'b1) n_done++;
    if (err_pulse === 1'b1) n_err++;
    if (ovl === 1'b1) n_ovl++;
    if (rx_dv === 1'b1) begin
      n_dv++;
      last_rx <= rx_data;
    end
  end
  // ****
  // Helpers
  // ****
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic cmp(input logic [63:0] got, input logic [63:0] expv);
    check_count++;
    if (got !== expv) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, expv);
    end
  endtask : cmp
  task automatic add(input logic b, input int n);
    repeat (n) exp[exp_len++] = b;
  endtask : add
  task automatic build(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
      input logic [63:0] dat, input logic [14:0] cx);
    logic raw [0:119];
    logic [14:0] crc;
    logic [18:0] hd;
    logic lst;
    int n, i, run;
    hd = {1'b0, id, rtr, 2'b00, dlc};
    n = 0;
    for (i = 18; i >= 0; i--) raw[n++] = hd[i];
    for (i = 0; i < (rtr ? 0 : 8 * dlc); i++) raw[n++] = dat[63-i];
    crc = CRC_INIT;
    for (i = 0; i < n; i++) crc = {crc[13:0], 1'b0} ^ ((raw[i] ^ crc[14]) ? CRC_POLY : 15'h0);
    crc = crc ^ cx;
    for (i = 14; i >= 0; i--) raw[n++] = crc[i];
    exp_len = 0;
    run = 0;
    lst = ~raw[0];
    for (i = 0; i < n; i++) begin
      run = (raw[i] == lst) ? run + 1 : 1;
      lst = raw[i];
      exp[exp_len++] = lst;
      if (run == 5) begin
        exp[exp_len++] = ~lst;
        lst = ~lst;
        run = 1;
      end
    end
  endtask : build
  task automatic grab(input int n);
    int i, k;
    k = 0;
    while (bus !== 1'b0 && k < 4000) begin
      @(posedge sys_clk);
      #1 k++;
    end
    if (k == 4000) begin
      num_errors++;
      conclude();
    end
    for (i = 0; i < n; i++) begin
      obs[i] = bus;
      repeat (4) @(posedge sys_clk);
      #1;
    end
    for (i = 0; i < n; i++) cmp(64'(obs[i]), 64'(exp[i]));
  endtask : grab
  task automatic start(input int s);
    repeat (64) @(posedge sys_clk);
    n_ok = 0;
    n_dv = 0;
    n_err = 0;
    n_done = 0;
    n_ovl = 0;
  endtask : start
  // ****
  // Scenarios
  // ****
  task automatic s_tx(input logic rtr, input logic [3:0] dlc, input logic [63:0] dat);
    int i;
    start(0);
    build(11'h6a5, rtr, dlc, dat, 15'h0);
    pat = '1;
    pat[exp_len+1] = 1'b0;
    plen <= 8'h9f;
    arm <= 1'b1;
    for (i = 0; i < (rtr ? 0 : 8); i++) begin
      @(posedge sys_clk);
      wr_valid <= 1'b1;
      wr_data <= dat[63-8*i -: 8];
    end
    @(posedge sys_clk);
    wr_valid <= 1'b0;
    tx_req <= 1'b1;
    {tx_id, tx_rtr, tx_dlc} <= {11'h6a5, rtr, dlc};
    @(posedge sys_clk);
    #1 cmp(64'(wr_ready), 64'(rtr));
    add(1'b1, 1);
    add(1'b0, 1);
    add(1'b1, 10);
    grab(exp_len);
    cmp(64'(n_done), 64'h1);
    cmp(64'(wr_ready), 64'h1);
    arm <= 1'b0;
  endtask : s_tx
  task automatic s_noack(input logic p);
    start(0);
    err_passive <= p;
    build(11'h0f0, 1'b1, 4'h0, 64'h0, 15'h0);
    add(1'b1, 2);
    add(p, 6);
    add(1'b1, 8);
    tx_req <= 1'b1;
    {tx_id, tx_rtr, tx_dlc} <= {11'h0f0, 1'b1, 4'h0};
    grab(exp_len);
    cmp(64'(n_err), 64'h1);
    cmp(64'(err_code), 64'(CFS_ERR_ACK));
    repeat (24) @(posedge sys_clk);
    #1 cmp(64'(tx_busy), 64'(p));
    @(posedge sys_clk);
    err_passive <= 1'b0;
  endtask : s_noack
  task automatic s_rx(input logic [14:0] cx);
    int i;
    start(0);
    build(11'h123, 1'b0, 4'h1, 64'ha500_0000_0000_0000, cx);
    add(1'b1, 10);
    if (cx == 15'h0) exp[exp_len-1] = 1'b0;
    for (i = 0; i < 160; i++) pat[i] = (i < exp_len) ? exp[i] : 1'b1;
    plen <= exp_len[7:0];
    arm <= 1'b1;
    if (cx != 15'h0) exp_len = exp_len - 7;
    add(1'b0, 6);
    add(1'b1, 8);
    grab(exp_len);
    cmp(64'(n_ok), 64'(cx == 15'h0));
    cmp(64'(n_ovl), 64'(cx == 15'h0));
    if (cx == 15'h0) begin
      cmp({rx_id, rx_dlc, last_rx, rx_rtr, rx_ext}, {11'h123, 4'h1, 8'ha5, 2'b00});
      cmp(64'(n_dv), 64'h1);
    end else cmp(64'(err_code), 64'(CFS_ERR_CRC));
    arm <= 1'b0;
  endtask : s_rx
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 cmp({bus_tx, tx_busy, err_code}, 64'h10);
    s_tx(1'b0, 4'h8, 64'h00ff_a55a_0f3c_8001);
    s_tx(1'b1, 4'h8, 64'h0);
    s_noack(1'b0);
    s_noack(1'b1);
    s_rx(15'h0);
    s_rx(15'h0001);
    conclude();
  end
endmodule : cfs_field_seq_tb
`default_nettype wire
